/* File: bench/media_walker_thread_generator_tb.sv */
// self-checking bench of the walker thread generator
`timescale 1ns/1ps
module media_walker_thread_generator_tb import mwg_pkg::*;;
    logic core_clk = 0, rstn = 0, hsel = 0, hwrite = 0, slow = 0;
    logic hreadyout, hresp, out_valid, out_ready;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
    mwg_out_s out_beat;
    mwg_out_s q[$];
    int n_errors = 0, cmp_count = 0;
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    mwg_walker DUT (.core_clk(core_clk), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .out_valid(out_valid),
        .out_beat(out_beat), .out_ready(out_ready));
    mwg_spawner_model u_sink (.core_clk(core_clk), .rstn(rstn),
        .slow(slow), .out_valid(out_valid), .out_ready(out_ready));
    always @(posedge core_clk) begin
        if (out_valid === 1'b1 && out_ready === 1'b1)
            q.push_back(out_beat);
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge core_clk);
        while (hreadyout !== 1'b1) @(posedge core_clk);
        rd = hrdata;
    endtask
    task automatic run(input logic [15:0] len, input logic [9:0] gsx,
                       input logic [3:0] cc, input logic [31:0] w0,
                       input logic lp);
        logic [31:0] c [CMD_WORDS];
        c = '{default: 32'h0000_0000};
        c[DW_LEN] = {16'h0000, len};
        c[DW_IDO] = 32'h0000_0003;
        c[DW_SBM] = 32'h0000_00A5;
        c[DW_CTL] = {4'h0, cc, 24'h00_0000};
        c[DW_BRES] = 32'h0004_0004;
        c[DW_LSTART] = 32'h0001_0000;
        c[DW_LEND] = 32'h0001_0000;
        c[DW_GRES] = 32'h0008_0008;
        c[DW_GSTART] = {16'h0002, 6'h00, gsx};
        if (lp) begin
            c[DW_CNT] = 32'h0001_0001;
            c[DW_LEND] = 32'h0001_0001;
            c[DW_LOSTR] = 32'h0001_0000;
            c[DW_LIUNIT] = 32'h0000_0001;
            c[DW_GOSTR] = 32'h0000_0004;
        end
        q.delete();
        for (int k = 0; k < CMD_WORDS; k++)
            bus(1'b1, REG_CMD_BASE + 4 * k, c[k]);
        bus(1'b1, REG_INLINE_BASE, w0);
        bus(1'b1, REG_INLINE_BASE + 4, ~w0);
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        repeat (3) @(posedge core_clk);
        rd = 32'h0000_0001;
        for (int i = 0; i < 300 && rd[0] !== 1'b0; i++)
            bus(1'b0, REG_STATUS, 32'h0000_0000);
    endtask
    task automatic expect_cmd(input int nt, input int nw,
                              input logic [9:0] x, input logic [31:0] w0);
        int b;
        b = 0;
        chk(rd[0], 1'b0);
        chk(rd[31:16], nt);
        chk(q.size(), nt * (nw + 1));
        for (int t = 0; t < nt && b < q.size(); t++) begin
            chk(q[b].hdr, 1'b1);
            chk(q[b].thr.x, x);
            chk(q[b].thr.y, 10'h003);
            chk(q[b].thr.color, t);
            chk({q[b].thr.use_sb, q[b].thr.sb_mask}, 9'h1A1);
            chk(q[b].thr.desc_ptr, 32'h0000_1060);
            chk(q[b].last, nw == 0);
            for (int i = 0; i < nw; i++) begin
                chk(q[b + 1 + i].word, i ? ~w0 : w0);
                chk(q[b + 1 + i].last, i == nw - 1);
            end
            b += nw + 1;
        end
    endtask
    task automatic t_reset();
        bus(1'b0, REG_CTRL, 32'h0000_0000);
        chk(rd, CTRL_RST);
        bus(1'b0, REG_FE_STATE, 32'h0000_0000);
        chk(rd, FE_STATE_RST);
        bus(1'b0, REG_DESC_BASE, 32'h0000_0000);
        chk(rd, DESC_BASE_RST);
        bus(1'b1, 32'h0000_00C0, 32'hFFFF_FFFF);
        bus(1'b0, 32'h0000_00C0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        // go refused while generic mode is still off
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        repeat (3) @(posedge core_clk);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd[0], 1'b0);
        chk(q.size(), 0);
    endtask
    task automatic t_walk();
        bus(1'b1, REG_FE_STATE, 32'h0000_01F3);
        bus(1'b1, REG_DESC_BASE, 32'h0000_1000);
        bus(1'b1, REG_CTRL, 32'h0000_0002);
        slow <= 1'b1;
        run(16'h0011, 10'h001, 4'h2, 32'h1234_5678, 1'b0);
        expect_cmd(3, 2, 10'h001, 32'h1234_5678);
    endtask
    task automatic t_reload();
        slow <= 1'b0;
        run(16'h0010, 10'h005, 4'h0, 32'hCAFE_0001, 1'b0);
        expect_cmd(1, 1, 10'h005, 32'hCAFE_0001);
        run(LEN_NO_INLINE, 10'h002, 4'h0, 32'h0BAD_0002, 1'b0);
        expect_cmd(1, 0, 10'h002, 32'h0000_0000);
        // start left of the global area, thread is skipped
        run(16'h0011, 10'h3FF, 4'h0, 32'h5555_0003, 1'b0);
        expect_cmd(0, 2, 10'h3FF, 32'h5555_0003);
    endtask
    // two inner steps, two local outer rows, two global outer columns
    task automatic t_loops();
        run(LEN_NO_INLINE, 10'h001, 4'h0, 32'h0000_0000, 1'b1);
        chk(rd[0], 1'b0);
        chk(rd[31:16], 8);
        chk(q.size(), 8);
        for (int t = 0; t < 8 && t < q.size(); t++) begin
            chk(q[t].thr.x, 1 + t[0] + 4 * t[2]);
            chk(q[t].thr.y, 3 + t[1]);
            chk(q[t].last, 1'b1);
        end
    endtask
    task automatic t_midreset();
        slow <= 1'b1;
        bus(1'b1, REG_CTRL, 32'h0000_0003);
        repeat (4) @(posedge core_clk);
        rstn <= 1'b0;
        @(posedge core_clk);
        chk(out_valid, 1'b0);
        chk(hreadyout, 1'b0);
        rstn <= 1'b1;
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        bus(1'b0, REG_CTRL, 32'h0000_0000);
        chk(rd, CTRL_RST);
    endtask
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_walk();
        t_reload();
        t_loops();
        t_midreset();
        tally_and_finish();
    end
endmodule // media_walker_thread_generator_tb
bind mwg_walker mwg_walker_props u_props (.core_clk(core_clk),
    .rstn(rstn), .hreadyout(hreadyout), .hresp(hresp),
    .out_valid(out_valid), .out_beat(out_beat), .out_ready(out_ready));

/* File: bench/mwg_spawner_model.sv */
// downstream spawner model accepting thread beats
`timescale 1ns/1ps
module mwg_spawner_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // stall control and stream handshake
    input wire logic slow,
    input wire logic out_valid,
    output logic out_ready
);
    logic [1:0] cnt_r;
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= 2'h0;
        end else if (out_valid) begin
            cnt_r <= cnt_r + 2'h1;
        end
    end
    // slow mode takes one beat in four so beats must be held
    assign out_ready = !slow || cnt_r == 2'h3;
endmodule // mwg_spawner_model

/* File: bench/mwg_walker_props.sv */
// checker of the thread stream and bus answer
`timescale 1ns/1ps
module mwg_walker_props import mwg_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // observed ports
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic out_valid,
    input mwg_out_s out_beat,
    input wire logic out_ready
);
    logic take;
    mwg_thr_s pt_r;
    assign take = out_valid && out_ready;
    // last accepted header, to compare colour repeats against
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pt_r <= '0;
        end else if (take && out_beat.hdr) begin
            pt_r <= out_beat.thr;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    sequence s_hdr;
        take && out_beat.hdr;
    endsequence
    sequence s_rep;
        s_hdr ##0 out_beat.thr.color != 4'h0;
    endsequence
    property p_bus_okay;
        $past(rstn) |-> hreadyout && !hresp;
    endproperty
    property p_hold;
        out_valid && !out_ready |=> out_valid && $stable(out_beat);
    endproperty
    property p_gap;
        take && out_beat.last |=> !out_valid;
    endproperty
    property p_inline;
        s_hdr ##0 !out_beat.last |=> out_valid && !out_beat.hdr;
    endproperty
    property p_pos;
        out_valid && out_beat.hdr |-> !out_beat.thr.x[9] && !out_beat.thr.y[9];
    endproperty
    property p_color;
        s_hdr |-> out_beat.thr.color == 4'h0
            || out_beat.thr.color == pt_r.color + 4'h1;
    endproperty
    property p_repeat;
        s_rep |-> out_beat.thr.x == pt_r.x && out_beat.thr.y == pt_r.y;
    endproperty
    property p_mask;
        s_rep |-> out_beat.thr.sb_mask == pt_r.sb_mask
            && out_beat.thr.use_sb == pt_r.use_sb;
    endproperty
    property p_desc;
        s_rep |-> out_beat.thr.desc_ptr == pt_r.desc_ptr;
    endproperty
    a_bus_okay: assert property (p_bus_okay)
        else $error("bus answer not ready or not okay");
    a_hold: assert property (p_hold)
        else $error("beat changed before acceptance");
    a_gap: assert property (p_gap)
        else $error("no idle cycle after last beat");
    a_inline: assert property (p_inline)
        else $error("inline word missing after header");
    a_pos: assert property (p_pos)
        else $error("thread outside global area");
    a_color: assert property (p_color)
        else $error("colour did not increment");
    a_repeat: assert property (p_repeat)
        else $error("colour repeat moved position");
    a_mask: assert property (p_mask)
        else $error("mask differs between threads");
    a_desc: assert property (p_desc)
        else $error("descriptor differs between threads");
endmodule // mwg_walker_props

/* File: core/mwg_pkg.sv */
// shared constants and types of the media walker thread generator
package mwg_pkg;
    localparam int ADDR_W = 12;
    localparam int CMD_WORDS = 17;
    localparam logic [11:0] REG_CMD_BASE = 12'h000;
    localparam logic [11:0] REG_CTRL = 12'h080;
    localparam logic [11:0] REG_FE_STATE = 12'h084;
    localparam logic [11:0] REG_DESC_BASE = 12'h088;
    localparam logic [11:0] REG_STATUS = 12'h08C;
    localparam logic [11:0] REG_INLINE_BASE = 12'h100;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_GENERIC_BIT = 1;
    localparam int FE_USE_SB_BIT = 8;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] FE_STATE_RST = 32'h0000_00FF;
    localparam logic [31:0] DESC_BASE_RST = 32'h0000_0000;
    localparam logic [15:0] LEN_NO_INLINE = 16'h000F;
    // command dword indices
    localparam int DW_LEN = 0;
    localparam int DW_IDO = 1;
    localparam int DW_SBM = 5;
    localparam int DW_CTL = 6;
    localparam int DW_CNT = 7;
    localparam int DW_BRES = 8;
    localparam int DW_LSTART = 9;
    localparam int DW_LEND = 10;
    localparam int DW_LOSTR = 11;
    localparam int DW_LIUNIT = 12;
    localparam int DW_GRES = 13;
    localparam int DW_GSTART = 14;
    localparam int DW_GOSTR = 15;
    localparam int DW_GIUNIT = 16;
    // field positions
    localparam int HI_LSB = 16;
    localparam int LO_LSB = 0;
    localparam int COLOR_LSB = 24;
    localparam int MID_EXTRA_LSB = 16;
    localparam int MID_UY_LSB = 12;
    localparam int MID_UX_LSB = 8;
    localparam int DESC_BYTES_DEF = 32;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HDR, ST_DATA} mwg_state_e;

    typedef struct packed {
        logic [9:0] x;
        logic [9:0] y;
        logic [3:0] color;
        logic use_sb;
        logic [7:0] sb_mask;
        logic [31:0] desc_ptr;
    } mwg_thr_s;

    typedef struct packed {
        logic hdr;
        logic last;
        mwg_thr_s thr;
        logic [31:0] word;
    } mwg_out_s;
endpackage

/* File: core/mwg_walker.sv */
// walker command expander with ahb-lite register slave
// Contract
// - one walker command expands into threads over a rectangle, each with X/Y
// - up to eight scoreboards driven from thread X/Y and loaded state
// - with scoreboard enabled, each thread's X/Y and color go to scoreboard
// - inline words are replicated into every generated thread
// - new inline payload per command accepted without any flush
// - length above 15 means inline present; exactly 15 means none
// - descriptor pointer is base plus 5-bit offset in whole descriptors
// - command mask ANDed with front end mask, shared by all threads
// - innermost step repeats count plus one times, color increments
// - middle loop: 5-bit extra steps, 2-bit signed X and Y units
// - global count bits 25:16, local count bits 9:0, both 10 bits
// - local loop bounded by 9-bit block width and height
// - local loop starts and ends at 9-bit X/Y positions
// - local outer loop advances by signed 10-bit X/Y strides
// - local inner loop steps by signed 10-bit X/Y units
// - global loop bounded by 9-bit width and height
// - global loop starts at signed 10-bit X/Y positions
// - global outer loop advances by signed 10-bit X/Y strides
// - global inner loop steps by signed 10-bit X/Y units
`timescale 1ns/1ps
module mwg_walker import mwg_pkg::*; #(
    parameter int INL_DEPTH = 16,
    parameter int DESC_BYTES = DESC_BYTES_DEF
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // thread stream to spawner and scoreboard
    output logic out_valid,
    output mwg_out_s out_beat,
    input wire logic out_ready
);
    initial begin
        if (INL_DEPTH < 1 || INL_DEPTH > 255)
            $error("INL_DEPTH out of range");
        if (DESC_BYTES < 1)
            $error("DESC_BYTES out of range");
    end

    typedef struct packed {
        logic rdy;
        logic [31:0] rdata;
        logic wr_pend;
        logic [ADDR_W-1:0] waddr;
        logic [CMD_WORDS-1:0][31:0] cmd;
        logic [INL_DEPTH-1:0][31:0] inl;
        logic [31:0] ctrl;
        logic [31:0] fe;
        logic [31:0] dbase;
        mwg_state_e state;
        logic fin;
        logic [7:0] inl_n;
        logic [7:0] idx;
        logic [3:0] c;
        logic [4:0] m;
        logic [9:0] lo;
        logic [9:0] go;
        // global loop base and current position, sign extended
        logic [11:0] gbx;
        logic [11:0] gby;
        logic [11:0] gx;
        logic [11:0] gy;
        // local, middle and inner positions, relative to global
        logic [11:0] lbx;
        logic [11:0] lby;
        logic [11:0] mbx;
        logic [11:0] mby;
        logic [11:0] lx;
        logic [11:0] ly;
        logic [7:0] mask;
        logic [31:0] dptr;
        logic [15:0] thr_cnt;
        logic ov;
        mwg_out_s ob;
    } mwg_st_s;

    mwg_st_s r, n;

    function automatic logic [11:0] sx10(input logic [9:0] v);
        return {{2{v[9]}}, v};
    endfunction

    function automatic logic [11:0] sx2(input logic [1:0] v);
        return {{10{v[1]}}, v};
    endfunction

    function automatic logic in_area(input logic [11:0] p,
                                    input logic [8:0] res);
        return !p[11] && (p < {3'h0, res});
    endfunction

    always_comb begin
        logic [ADDR_W-1:0] a;
        logic go_req;
        logic [15:0] len;
        logic [11:0] cx;
        logic [11:0] cy;
        logic [11:0] nlx;
        logic [11:0] nly;
        logic [11:0] ngx;
        logic [11:0] ngy;
        logic [11:0] t;
        logic inner_end;
        logic ginner_end;
        logic [8:0] bresx;
        logic [8:0] bresy;
        logic [8:0] gresx;
        logic [8:0] gresy;
        logic [11:0] endx;
        logic [11:0] endy;
        logic [11:0] liux;
        logic [11:0] liuy;
        logic [11:0] giux;
        logic [11:0] giuy;
        logic [3:0] ccnt;
        logic [4:0] mext;
        logic [9:0] lcnt;
        logic [9:0] gcnt;
        a = haddr[ADDR_W-1:0];
        go_req = 1'b0;
        len = r.cmd[DW_LEN][15:0];
        cx = 12'h000;
        cy = 12'h000;
        nlx = 12'h000;
        nly = 12'h000;
        ngx = 12'h000;
        ngy = 12'h000;
        t = 12'h000;
        inner_end = 1'b0;
        ginner_end = 1'b0;
        bresx = r.cmd[DW_BRES][LO_LSB +: 9];
        bresy = r.cmd[DW_BRES][HI_LSB +: 9];
        gresx = r.cmd[DW_GRES][LO_LSB +: 9];
        gresy = r.cmd[DW_GRES][HI_LSB +: 9];
        endx = {3'h0, r.cmd[DW_LEND][LO_LSB +: 9]};
        endy = {3'h0, r.cmd[DW_LEND][HI_LSB +: 9]};
        liux = sx10(r.cmd[DW_LIUNIT][LO_LSB +: 10]);
        liuy = sx10(r.cmd[DW_LIUNIT][HI_LSB +: 10]);
        giux = sx10(r.cmd[DW_GIUNIT][LO_LSB +: 10]);
        giuy = sx10(r.cmd[DW_GIUNIT][HI_LSB +: 10]);
        ccnt = r.cmd[DW_CTL][COLOR_LSB +: 4];
        mext = r.cmd[DW_CTL][MID_EXTRA_LSB +: 5];
        lcnt = r.cmd[DW_CNT][LO_LSB +: 10];
        gcnt = r.cmd[DW_CNT][HI_LSB +: 10];
        n = r;

        // bus: zero-wait slave, read data prepared in the address phase
        n.rdy = 1'b1;
        n.wr_pend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            n.wr_pend = hwrite;
            n.waddr = a;
            n.rdata = 32'h0000_0000;
            if (!hwrite) begin
                if (a < REG_CMD_BASE + 12'(4 * CMD_WORDS))
                    n.rdata = r.cmd[a[ADDR_W-1:2]];
                else if (a >= REG_INLINE_BASE &&
                         a < REG_INLINE_BASE + 12'(4 * INL_DEPTH))
                    n.rdata = r.inl[a[ADDR_W-1:2] - REG_INLINE_BASE[11:2]];
                else if (a == REG_CTRL)
                    n.rdata = r.ctrl;
                else if (a == REG_FE_STATE)
                    n.rdata = r.fe;
                else if (a == REG_DESC_BASE)
                    n.rdata = r.dbase;
                else if (a == REG_STATUS)
                    n.rdata = {r.thr_cnt, 15'h0000, r.state != ST_IDLE};
            end
        end
        // payload and command words stay frozen while a walk is running
        if (r.wr_pend) begin
            if (r.waddr == REG_CTRL) begin
                n.ctrl[CTRL_GENERIC_BIT] = hwdata[CTRL_GENERIC_BIT];
                // only generic mode lets a walk start
                go_req = hwdata[CTRL_GO_BIT] &&
                         r.ctrl[CTRL_GENERIC_BIT];
            end else if (r.waddr == REG_FE_STATE) begin
                n.fe = {23'h00_0000, hwdata[8:0]};
            end else if (r.waddr == REG_DESC_BASE) begin
                n.dbase = hwdata;
            end else if (r.state == ST_IDLE) begin
                if (r.waddr < REG_CMD_BASE + 12'(4 * CMD_WORDS))
                    n.cmd[r.waddr[ADDR_W-1:2]] = hwdata;
                else if (r.waddr >= REG_INLINE_BASE &&
                         r.waddr < REG_INLINE_BASE + 12'(4 * INL_DEPTH))
                    n.inl[r.waddr[ADDR_W-1:2] - REG_INLINE_BASE[11:2]] =
                        hwdata;
            end
        end

        unique case (r.state)
            ST_IDLE: begin
                // dual, quad and repel bits of the control word are ignored
                if (go_req) begin
                    n.state = ST_RUN;
                    n.fin = 1'b0;
                    n.thr_cnt = 16'h0000;
                    // indirect data is never fetched; payload is inline
                    if (len > LEN_NO_INLINE) begin
                        t = 12'(len - LEN_NO_INLINE);
                        n.inl_n = (t > 12'(INL_DEPTH)) ?
                                  8'(INL_DEPTH) : t[7:0];
                    end else begin
                        n.inl_n = 8'h00;
                    end
                    n.mask = r.cmd[DW_SBM][7:0] & r.fe[7:0];
                    n.dptr = r.dbase + 32'(r.cmd[DW_IDO][4:0]) *
                             32'(DESC_BYTES);
                    n.c = 4'h0;
                    n.m = 5'h00;
                    n.lo = 10'h000;
                    n.go = 10'h000;
                    n.gbx = sx10(r.cmd[DW_GSTART][LO_LSB +: 10]);
                    n.gby = sx10(r.cmd[DW_GSTART][HI_LSB +: 10]);
                    n.gx = n.gbx;
                    n.gy = n.gby;
                    n.lbx = {3'h0, r.cmd[DW_LSTART][LO_LSB +: 9]};
                    n.lby = {3'h0, r.cmd[DW_LSTART][HI_LSB +: 9]};
                    n.mbx = n.lbx;
                    n.mby = n.lby;
                    n.lx = n.lbx;
                    n.ly = n.lby;
                end
            end
            ST_RUN: begin
                // one candidate per cycle; a skipped position still costs one
                cx = r.gx + r.lx;
                cy = r.gy + r.ly;
                if (in_area(cx, gresx) && in_area(cy, gresy)) begin
                    n.state = ST_HDR;
                    n.ov = 1'b1;
                    n.thr_cnt = r.thr_cnt + 16'h0001;
                    n.ob.hdr = 1'b1;
                    n.ob.last = (r.inl_n == 8'h00);
                    n.ob.word = 32'h0000_0000;
                    n.ob.thr.x = cx[9:0];
                    n.ob.thr.y = cy[9:0];
                    n.ob.thr.color = r.c;
                    n.ob.thr.use_sb = r.fe[FE_USE_SB_BIT];
                    n.ob.thr.sb_mask = r.mask;
                    n.ob.thr.desc_ptr = r.dptr;
                end
                // advance: color, local inner, middle, local outer,
                // global inner, global outer
                if (r.c != ccnt) begin
                    n.c = r.c + 4'h1;
                end else begin
                    n.c = 4'h0;
                    nlx = r.lx + liux;
                    nly = r.ly + liuy;
                    // zero X and Y units, a reached end or leaving the block closes the inner walk
                    inner_end = (liux == 12'h000 && liuy == 12'h000) ||
                                (liux != 12'h000 && r.lx == endx) ||
                                (liuy != 12'h000 && r.ly == endy) ||
                                !in_area(nlx, bresx) ||
                                !in_area(nly, bresy);
                    if (!inner_end) begin
                        n.lx = nlx;
                        n.ly = nly;
                    end else if (r.m != mext) begin
                        n.m = r.m + 5'h01;
                        n.mbx = r.mbx + sx2(r.cmd[DW_CTL][MID_UX_LSB +: 2]);
                        n.mby = r.mby + sx2(r.cmd[DW_CTL][MID_UY_LSB +: 2]);
                        n.lx = n.mbx;
                        n.ly = n.mby;
                    end else if (r.lo != lcnt) begin
                        n.m = 5'h00;
                        n.lo = r.lo + 10'h001;
                        n.lbx = r.lbx +
                                sx10(r.cmd[DW_LOSTR][LO_LSB +: 10]);
                        n.lby = r.lby +
                                sx10(r.cmd[DW_LOSTR][HI_LSB +: 10]);
                        n.mbx = n.lbx;
                        n.mby = n.lby;
                        n.lx = n.lbx;
                        n.ly = n.lby;
                    end else begin
                        n.m = 5'h00;
                        n.lo = 10'h000;
                        n.lbx = {3'h0, r.cmd[DW_LSTART][LO_LSB +: 9]};
                        n.lby = {3'h0, r.cmd[DW_LSTART][HI_LSB +: 9]};
                        n.mbx = n.lbx;
                        n.mby = n.lby;
                        n.lx = n.lbx;
                        n.ly = n.lby;
                        ngx = r.gx + giux;
                        ngy = r.gy + giuy;
                        ginner_end = (giux == 12'h000 && giuy == 12'h000) ||
                                     !in_area(ngx, gresx) ||
                                     !in_area(ngy, gresy);
                        if (!ginner_end) begin
                            n.gx = ngx;
                            n.gy = ngy;
                        end else if (r.go != gcnt) begin
                            n.go = r.go + 10'h001;
                            n.gbx = r.gbx +
                                    sx10(r.cmd[DW_GOSTR][LO_LSB +: 10]);
                            n.gby = r.gby +
                                    sx10(r.cmd[DW_GOSTR][HI_LSB +: 10]);
                            n.gx = n.gbx;
                            n.gy = n.gby;
                        end else begin
                            n.fin = 1'b1;
                            if (n.state == ST_RUN)
                                n.state = ST_IDLE;
                        end
                    end
                end
            end
            ST_HDR: begin
                if (out_ready) begin
                    if (r.inl_n != 8'h00) begin
                        n.state = ST_DATA;
                        n.ob.hdr = 1'b0;
                        n.ob.word = r.inl[0];
                        n.ob.last = (r.inl_n == 8'h01);
                        n.idx = 8'h01;
                    end else begin
                        n.ov = 1'b0;
                        n.state = r.fin ? ST_IDLE : ST_RUN;
                    end
                end
            end
            ST_DATA: begin
                if (out_ready) begin
                    if (r.ob.last) begin
                        n.ov = 1'b0;
                        n.state = r.fin ? ST_IDLE : ST_RUN;
                    end else begin
                        // same words go to every thread of this command
                        n.ob.word = r.inl[r.idx];
                        n.ob.last = (r.idx + 8'h01 == r.inl_n);
                        n.idx = r.idx + 8'h01;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
            r.ctrl <= CTRL_RST;
            r.fe <= FE_STATE_RST;
            r.dbase <= DESC_BASE_RST;
            r.state <= ST_IDLE;
        end else begin
            r <= n;
        end
    end

    assign hreadyout = r.rdy;
    assign hresp = 1'b0;
    assign hrdata = r.rdata;
    assign out_valid = r.ov;
    assign out_beat = r.ob;
endmodule // mwg_walker
